// ===== core/gtm_regs.vh
`ifndef GTM_REGS_VH
`define GTM_REGS_VH
// Register byte offsets
`define GTM_CFG 12'h000
`define GTM_AMODE 12'h004
`define GTM_BMODE 12'h008
`define GTM_CTL 12'h00C
`define GTM_IMR 12'h018
`define GTM_RIS 12'h01C
`define GTM_MIS 12'h020
`define GTM_ICR 12'h024
`define GTM_AILR 12'h028
`define GTM_BILR 12'h02C
`define GTM_AMATCH 12'h030
`define GTM_BMATCH 12'h034
`define GTM_APRE 12'h038
`define GTM_BPRE 12'h03C
`define GTM_AVAL 12'h048
`define GTM_BVAL 12'h04C
// Configuration values
`define GTM_CFG_32 3'h0
`define GTM_CFG_RTC 3'h1
`define GTM_CFG_SPLIT 3'h4
// Mode field values, mode register bits [1:0], then CMR and AMS bit positions
`define GTM_MR_ONE 2'h1
`define GTM_MR_PER 2'h2
`define GTM_MR_CAP 2'h3
`define GTM_MODE_CMR 2
`define GTM_MODE_AMS 3
// Control bits within each timer byte (timer B adds 8)
`define GTM_CTL_EN 0
`define GTM_CTL_STALL 1
`define GTM_CTL_EVLO 2
`define GTM_CTL_RTC_STALL_ENABLE 4
`define GTM_CTL_OTE 5
`define GTM_CTL_PWML 6
// Edge select codes
`define GTM_EV_FALL 2'h1
`define GTM_EV_BOTH 2'h3
// Status bits (timer B adds 8)
`define GTM_ST_TO 0
`define GTM_ST_CM 1
`define GTM_ST_CE 2
`define GTM_ST_RTC 3
// Reset values, then the RTC start and rollover loads
`define GTM_ILR_RST 32'hFFFFFFFF
`define GTM_CNT_RST 32'hFFFFFFFF
`define GTM_RTC_START 32'h00000001
`define GTM_RTC_ROLL 32'h00000000
// Pin clock cycles per real-time-clock second
`define GTM_RTC_DIV 32768
`endif

// ===== core/gtm_timer.v
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "gtm_regs.vh"

// Behaviour
// - RTC enable starts up-count at one
// - RTC match rolls counter to zero
// - RTC match sets raw, masked, interrupt
// - RTC stall enable ignores stall bits
// - Configuration four splits into two timers
// - Sixteen-bit down-counter with eight-bit prescaler
// - Count down, reload after reaching zero
// - One-shot clears enable; periodic continues
// - Zero sets sticky time-out flag, masked
// - Trigger pulse only with trigger enable
// - Interval load write reloads counter next cycle
// - Stall bit freezes count during stall
// - Prescale value plus one clocks per count
// - No prescaling in capture and PWM modes
// - Edge count on selected pin edges
// - Match sets flag, reloads, clears enable
// - Edge time free-runs, reloads at zero
// - Edge latches count, sets capture flag
// - PWM selected by alternate, capture, mode
// - PWM reloads at zero, no flags
// - PWM high at load, low at match
// - Configuration zero/one select 32-bit modes
// - Mode one one-shot, two periodic
// - Pin clock divided to one hertz
module gtm_timer #(
  parameter RTC_DIV = `GTM_RTC_DIV
) (
  input wire clk, // 100 MHz system clock
  input wire reset, // Synchronous, active high
  input wire ce, // Clock enable, freezes all state when low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error on unmapped address
  input wire stallIn, // Debug stall request, same clock
  input wire [1:0] capturePin, // Capture pins, asynchronous
  output reg [1:0] pwmOut, // PWM outputs
  output reg [1:0] trigOut, // Time-out trigger pulses
  output reg irq // Timer interrupt
);
  reg [2:0] cfg_q;
  reg [7:0] mode_q;
  reg [15:0] ctl_q;
  reg [10:0] imr_q;
  reg [10:0] ris_q;
  reg [31:0] ilr_q;
  reg [31:0] match_q;
  reg [15:0] pre_q;
  reg [15:0] preCnt_q;
  reg [31:0] cnt_q;
  reg [31:0] cap_q;
  reg [1:0] lvl_q;
  reg [1:0] pinS1_q;
  reg [1:0] pinS2_q;
  reg [1:0] pinS3_q;
  reg [15:0] rtcDiv_q;
  reg rtcEnPrev_q;
  reg [31:0] cnt32_d;
  reg [15:0] ctl_d;
  reg [31:0] rdata_d;
  reg rdOk_d;

  wire acc = psel & penable & ~pready;
  wire wr = acc & pwrite;
  wire split = cfg_q == `GTM_CFG_SPLIT;
  wire wide = ~split;
  wire [1:0] ilrWr;
  wire [1:0] preWr;
  wire [31:0] cntN;
  wire [15:0] preN;
  wire [1:0] toEv;
  wire [1:0] cmEv;
  wire [1:0] ceEv;
  wire [1:0] enClr;
  wire [1:0] etim;
  wire [1:0] lvlN;
  wire [1:0] pinRise = pinS2_q & ~pinS3_q;
  wire [1:0] pinFall = ~pinS2_q & pinS3_q;

  assign ilrWr[0] = wr & (paddr == `GTM_AILR);
  assign ilrWr[1] = wr & (paddr == `GTM_BILR) & split;
  assign preWr[0] = wr & (paddr == `GTM_APRE);
  assign preWr[1] = wr & (paddr == `GTM_BPRE);

  genvar n;
  generate
    for (n = 0; n < 2; n = n + 1) begin : gTim
      wire [3:0] md = mode_q[4*n+3:4*n];
      wire [7:0] ct = ctl_q[8*n+7:8*n];
      wire [15:0] cnt = cnt_q[16*n+15:16*n];
      wire [15:0] ilr = ilr_q[16*n+15:16*n];
      wire [15:0] mat = match_q[16*n+15:16*n];
      wire [7:0] pcnt = preCnt_q[8*n+7:8*n];
      wire [7:0] pre = pre_q[8*n+7:8*n];
      wire [1:0] ev = ct[`GTM_CTL_EVLO+1:`GTM_CTL_EVLO];
      wire isCap = md[1:0] == `GTM_MR_CAP;
      wire isEcnt = isCap & ~md[`GTM_MODE_CMR];
      wire isEtim = isCap & md[`GTM_MODE_CMR];
      wire isPwm = md[`GTM_MODE_AMS] & ~md[`GTM_MODE_CMR] &
        (md[1:0] == `GTM_MR_PER);
      wire isOne = md[1:0] == `GTM_MR_ONE;
      wire isTmr = ~md[`GTM_MODE_AMS] & (isOne | md[1:0] == `GTM_MR_PER);
      wire run = split & ct[`GTM_CTL_EN] & ~(ct[`GTM_CTL_STALL] & stallIn);
      // Edge time never takes both edges; that code falls back to rising
      wire evHit = (ev == `GTM_EV_FALL) ? pinFall[n] :
        (ev == `GTM_EV_BOTH && !isEtim) ? (pinRise[n] | pinFall[n]) :
        pinRise[n];
      wire preEnd = ~isTmr | (pcnt == 8'h00);
      wire tick = run & (isEcnt ? evHit : preEnd);
      wire [15:0] dec = cnt - 16'h0001;
      wire ecMatch = isEcnt & tick & (dec == mat);
      wire reload = tick & ~isEcnt & (cnt == 16'h0000);
      assign toEv[n] = reload & isTmr;
      assign cmEv[n] = ecMatch;
      assign ceEv[n] = run & isEtim & evHit;
      assign etim[n] = isEtim;
      assign enClr[n] = ecMatch | (toEv[n] & isOne);
      assign cntN[16*n+15:16*n] = ilrWr[n] ? pwdata[15:0] :
        (ecMatch | reload) ? ilr : tick ? dec : cnt;
      assign preN[8*n+7:8*n] = preWr[n] ? pwdata[7:0] :
        (run & isTmr) ? ((pcnt == 8'h00) ? pre : pcnt - 8'h01) : pcnt;
      assign lvlN[n] = ~isPwm ? 1'b0 :
        (run & cnt == ilr) ? 1'b1 : (cnt == mat) ? 1'b0 : lvl_q[n];
    end
  endgenerate

  // Real-time clock: one tick per RTC_DIV rising edges of pin A
  wire rtcMode = cfg_q == `GTM_CFG_RTC;
  wire rtcTick = rtcMode & pinRise[0] &
    (rtcDiv_q == RTC_DIV[15:0] - 16'h0001);
  wire enA = ctl_q[`GTM_CTL_EN];
  wire stall32 = (ctl_q[`GTM_CTL_STALL] | ctl_q[8+`GTM_CTL_STALL]) & stallIn;
  wire run32 = wide & enA &
    ~(stall32 & ~(rtcMode & ctl_q[`GTM_CTL_RTC_STALL_ENABLE]));
  wire rtcEv = run32 & rtcMode & rtcTick & (cnt_q == match_q);
  wire to32Ev = run32 & ~rtcMode & (cnt_q == 32'h00000000);
  wire oneA = mode_q[1:0] == `GTM_MR_ONE;
  wire ilr32Wr = wr & wide & (paddr == `GTM_AILR);

  always @* begin
    cnt32_d = cnt_q;
    if (ilr32Wr) begin
      cnt32_d = pwdata;
    end else if (rtcMode && enA && !rtcEnPrev_q) begin
      cnt32_d = `GTM_RTC_START;
    end else if (rtcMode) begin
      if (rtcEv) begin
        cnt32_d = `GTM_RTC_ROLL;
      end else if (run32 && rtcTick) begin
        cnt32_d = cnt_q + 32'h00000001;
      end
    end else if (run32) begin
      cnt32_d = to32Ev ? ilr_q : cnt_q - 32'h00000001;
    end
  end

  wire [10:0] setV = {ceEv[1], cmEv[1], toEv[1], 4'h0, rtcEv,
    ceEv[0], cmEv[0], toEv[0] | to32Ev};
  wire [10:0] misV = ris_q & imr_q;
  wire [31:0] valA = wide ? cnt_q : {16'h0000, etim[0] ? cap_q[15:0] : cnt_q[15:0]};
  wire [31:0] valB = {16'h0000, etim[1] ? cap_q[31:16] : cnt_q[31:16]};

  always @* begin
    ctl_d = ctl_q;
    if (wr && paddr == `GTM_CTL) begin
      ctl_d = pwdata[15:0];
    end
    // Hardware disable wins over a same-cycle software write
    if (enClr[0] || (to32Ev && oneA)) begin
      ctl_d[`GTM_CTL_EN] = 1'b0;
    end
    if (enClr[1]) begin
      ctl_d[8+`GTM_CTL_EN] = 1'b0;
    end
  end

  always @* begin
    rdata_d = 32'h00000000;
    rdOk_d = 1'b1;
    case (paddr)
      `GTM_CFG: rdata_d = {29'h0, cfg_q};
      `GTM_AMODE: rdata_d = {28'h0, mode_q[3:0]};
      `GTM_BMODE: rdata_d = {28'h0, mode_q[7:4]};
      `GTM_CTL: rdata_d = {16'h0000, ctl_q};
      `GTM_IMR: rdata_d = {21'h0, imr_q};
      `GTM_RIS: rdata_d = {21'h0, ris_q};
      `GTM_MIS: rdata_d = {21'h0, misV};
      `GTM_ICR: rdata_d = 32'h00000000;
      `GTM_AILR: rdata_d = wide ? ilr_q : {16'h0000, ilr_q[15:0]};
      `GTM_BILR: rdata_d = {16'h0000, ilr_q[31:16]};
      `GTM_AMATCH: rdata_d = wide ? match_q : {16'h0000, match_q[15:0]};
      `GTM_BMATCH: rdata_d = {16'h0000, match_q[31:16]};
      `GTM_APRE: rdata_d = {24'h000000, pre_q[7:0]};
      `GTM_BPRE: rdata_d = {24'h000000, pre_q[15:8]};
      `GTM_AVAL: rdata_d = valA;
      `GTM_BVAL: rdata_d = valB;
      default: rdOk_d = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= acc;
      pslverr <= acc & ~rdOk_d;
      if (acc && !pwrite) begin
        prdata <= rdata_d;
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      cfg_q <= 3'h0;
      mode_q <= 8'h00;
      imr_q <= 11'h000;
      ilr_q <= `GTM_ILR_RST;
      match_q <= 32'h00000000;
      pre_q <= 16'h0000;
    end else if (ce && wr) begin
      case (paddr)
        `GTM_CFG: cfg_q <= pwdata[2:0];
        `GTM_AMODE: mode_q[3:0] <= pwdata[3:0];
        `GTM_BMODE: mode_q[7:4] <= pwdata[3:0];
        `GTM_IMR: imr_q <= pwdata[10:0];
        `GTM_AILR: begin
          if (wide) begin
            ilr_q <= pwdata;
          end else begin
            ilr_q[15:0] <= pwdata[15:0];
          end
        end
        `GTM_BILR: ilr_q[31:16] <= pwdata[15:0];
        `GTM_AMATCH: begin
          if (wide) begin
            match_q <= pwdata;
          end else begin
            match_q[15:0] <= pwdata[15:0];
          end
        end
        `GTM_BMATCH: match_q[31:16] <= pwdata[15:0];
        `GTM_APRE: pre_q[7:0] <= pwdata[7:0];
        `GTM_BPRE: pre_q[15:8] <= pwdata[7:0];
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      ctl_q <= 16'h0000;
      ris_q <= 11'h000;
      cnt_q <= `GTM_CNT_RST;
      preCnt_q <= 16'h0000;
      cap_q <= 32'h00000000;
      lvl_q <= 2'b00;
      pwmOut <= 2'b00;
      trigOut <= 2'b00;
      irq <= 1'b0;
      rtcDiv_q <= 16'h0000;
      rtcEnPrev_q <= 1'b0;
      pinS1_q <= 2'b00;
      pinS2_q <= 2'b00;
      pinS3_q <= 2'b00;
    end else if (ce) begin
      pinS1_q <= capturePin;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      ctl_q <= ctl_d;
      cnt_q <= split ? cntN : cnt32_d;
      preCnt_q <= preN;
      rtcEnPrev_q <= rtcMode & enA;
      if (rtcMode && pinRise[0]) begin
        rtcDiv_q <= rtcTick ? 16'h0000 : rtcDiv_q + 16'h0001;
      end
      // A new event in the clearing cycle keeps its flag set
      if (wr && paddr == `GTM_ICR) begin
        ris_q <= (ris_q & ~pwdata[10:0]) | setV;
      end else begin
        ris_q <= ris_q | setV;
      end
      irq <= |(((ris_q | setV) & imr_q) &
        ~((wr && paddr == `GTM_ICR) ? pwdata[10:0] & ~setV : 11'h000));
      if (ceEv[0]) begin
        cap_q[15:0] <= cnt_q[15:0];
      end
      if (ceEv[1]) begin
        cap_q[31:16] <= cnt_q[31:16];
      end
      lvl_q <= lvlN;
      pwmOut <= lvlN ^ {ctl_q[8+`GTM_CTL_PWML], ctl_q[`GTM_CTL_PWML]};
      trigOut <= {toEv[1] & ctl_q[8+`GTM_CTL_OTE],
        (toEv[0] | to32Ev) & ctl_q[`GTM_CTL_OTE]};
    end
  end
endmodule // gtm_timer

// ===== test/gtm_checker.sv
`timescale 1ns/1ns
`include "gtm_regs.vh"
module gtm_checker (
  input wire clk, // Clock
  input wire reset, // Reset
  input wire ce, // Enable
  input wire psel, // Select
  input wire penable, // Access
  input wire pwrite, // Direction
  input wire [11:0] paddr, // Address
  input wire [31:0] pwdata, // Write data
  input wire [31:0] prdata, // Read data
  input wire pready, // Ready
  input wire pslverr, // Error
  input wire stallIn, // Stall
  input wire [1:0] capturePin, // Pins
  input wire [1:0] pwmOut, // PWM
  input wire [1:0] trigOut, // Triggers
  input wire irq // Interrupt
);
  logic [31:0] imr_q;
  logic [31:0] ctl_q;
  wire takeWr = psel && penable && !pready && ce && pwrite;
  // Shadow copies so output checks need no internal probes
  always @(posedge clk) begin
    if (reset) begin
      imr_q <= 32'h0;
      ctl_q <= 32'h0;
    end else if (takeWr && paddr == `GTM_IMR) begin
      imr_q <= pwdata;
    end else if (takeWr && paddr == `GTM_CTL) begin
      ctl_q <= pwdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_ready_wait: assert property (psel && penable && !pready && ce |=> pready)
    else $error("ready missing");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  a_err_unmapped: assert property (psel && penable && !pready && paddr == 12'h010 |=> pslverr)
    else $error("no error on gap");
  a_err_mapped: assert property (psel && penable && !pready && paddr == `GTM_CFG |=> !pslverr)
    else $error("error on mapped");
  a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("gap read not zero");
  a_clear_reads_zero: assert property (pready && !pwrite && paddr == `GTM_ICR |-> prdata == 32'h0)
    else $error("clear reg read");
  a_irq_masked: assert property (irq |-> imr_q != 32'h0 || $past(imr_q) != 32'h0)
    else $error("irq while masked");
  a_trig_a_gate: assert property (trigOut[0] |-> ctl_q[5] || $past(ctl_q[5]))
    else $error("trigger A ungated");
  a_trig_b_gate: assert property (trigOut[1] |-> ctl_q[13] || $past(ctl_q[13]))
    else $error("trigger B ungated");
endmodule // gtm_checker
bind gtm_timer gtm_checker i_chk (.clk(clk), .reset(reset), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .stallIn(stallIn), .capturePin(capturePin),
  .pwmOut(pwmOut), .trigOut(trigOut), .irq(irq));

// ===== test/gtm_pin_model.sv
`timescale 1ns/1ns
module gtm_pin_model (
  input wire clk, // System clock
  input wire [1:0] run, // Toggle request per pin
  output logic [1:0] pin // Capture pin levels
);
  logic [1:0] div_q = 2'h0;
  initial pin = 2'h0;
  // Pin 0 also serves as the slow real-time clock source
  always @(posedge clk) begin
    div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
    if (div_q == 2'h2) begin
      pin <= pin ^ run; // Three clocks per level
    end
  end
endmodule // gtm_pin_model

// ===== test/gtm_timer_test.sv
`timescale 1ns/1ns
`include "gtm_regs.vh"
module gtm_timer_test;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, stallIn = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, r, v;
  logic [1:0] run = 0;
  wire [31:0] prdata;
  wire pready, pslverr, irq;
  wire [1:0] capturePin, pwmOut, trigOut;
  int n_fail = 0, comparisons = 0, cyc = 0, k;
  always #5 clk = ~clk;
  // Small divider keeps a real-time second to a few dozen clocks
  gtm_timer #(.RTC_DIV(4)) i_dut (.clk(clk), .reset(reset), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stallIn(stallIn), .capturePin(capturePin),
    .pwmOut(pwmOut), .trigOut(trigOut), .irq(irq));
  gtm_pin_model i_pins (.clk(clk), .run(run), .pin(capturePin));
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      end_sim;
    end
  end
  task chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a hung wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", pready, 1'b1);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] m, x, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, r & m, x);
  endtask
  task waitIrq(input int m);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < m) begin
      @(posedge clk);
      n++;
    end
    chk("irq", irq, 1'b1);
  endtask
  task hi(input int m, input int w);
    logic [3:0] o;
    k = 0;
    repeat (m) begin
      @(posedge clk);
      o = {pwmOut, trigOut};
      k += o[w];
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rdc(`GTM_CFG, 32'hFFFFFFFF, 32'h0, "cfg");
    rdc(`GTM_AILR, 32'hFFFF, 32'hFFFF, "ldrst");
    apb(1'b0, 12'h010, 32'h0);
    chk("gaperr", e, 1'b1);
    wr(`GTM_IMR, 32'hF);
    rdc(`GTM_IMR, 32'hFFFFFFFF, 32'hF, "imr");
    wr(`GTM_CFG, 32'h4);
    wr(`GTM_AMODE, 32'h1);
    wr(`GTM_APRE, 32'h1);
    wr(`GTM_AILR, 32'h3);
    wr(`GTM_CTL, 32'h21);
    waitIrq(50);
    chk("trigA", trigOut[0], 1'b1);
    rdc(`GTM_RIS, 32'h1, 32'h1, "toflag");
    rdc(`GTM_CTL, 32'h1, 32'h0, "oneshot");
    rdc(`GTM_AVAL, 32'hFFFF, 32'h3, "reload");
    wr(`GTM_ICR, 32'h1);
    rdc(`GTM_RIS, 32'h1, 32'h0, "toclr");
    chk("irqlow", irq, 1'b0);
    wr(`GTM_BMODE, 32'h2);
    wr(`GTM_BILR, 32'h5);
    wr(`GTM_CTL, 32'h2100);
    hi(120, 1);
    chk("periodic", k >= 19 && k <= 21, 1'b1);
    stallIn <= 1'b1;
    wr(`GTM_CTL, 32'h0300);
    apb(1'b0, `GTM_BVAL, 32'h0);
    v = r;
    rdc(`GTM_BVAL, 32'hFFFFFFFF, v, "stall");
    stallIn <= 1'b0;
    hi(60, 1);
    chk("notrig", k, 32'h0);
    wr(`GTM_CTL, 32'h0);
    wr(`GTM_ICR, 32'hFFFFFFFF);
    wr(`GTM_AMODE, 32'h3);
    wr(`GTM_AILR, 32'hA);
    wr(`GTM_AMATCH, 32'h6); // Four edges
    wr(`GTM_CTL, 32'hD);
    run <= 2'h1;
    repeat (40) @(posedge clk);
    run <= 2'h0;
    rdc(`GTM_RIS, 32'h2, 32'h2, "match");
    rdc(`GTM_CTL, 32'h1, 32'h0, "cntstop");
    rdc(`GTM_AVAL, 32'hFFFF, 32'hA, "cntload");
    wr(`GTM_ICR, 32'hFFFFFFFF);
    wr(`GTM_AMODE, 32'hA);
    wr(`GTM_AILR, 32'h9);
    wr(`GTM_AMATCH, 32'h7);
    wr(`GTM_CTL, 32'h1);
    hi(100, 2);
    chk("duty", k >= 17 && k <= 23, 1'b1);
    wr(`GTM_CTL, 32'h41);
    hi(100, 2);
    chk("inverted", k >= 77 && k <= 83, 1'b1);
    rdc(`GTM_RIS, 32'hFFFFFFFF, 32'h0, "pwmflag");
    chk("pwmidleb", pwmOut[1], 1'b0);
    wr(`GTM_BMODE, 32'h7);
    wr(`GTM_BILR, 32'h3F);
    wr(`GTM_IMR, 32'h400);
    wr(`GTM_CTL, 32'h0100);
    run <= 2'h2;
    waitIrq(60);
    run <= 2'h0;
    rdc(`GTM_RIS, 32'h400, 32'h400, "capflag");
    apb(1'b0, `GTM_BVAL, 32'h0);
    v = r;
    chk("capval", v <= 32'h3F, 1'b1);
    // Counter keeps running, so a live value would differ here
    repeat (7) @(posedge clk);
    rdc(`GTM_BVAL, 32'hFFFFFFFF, v, "caphold");
    wr(`GTM_CTL, 32'h0);
    wr(`GTM_CFG, 32'h1);
    wr(`GTM_AMATCH, 32'h2);
    wr(`GTM_IMR, 32'h8);
    stallIn <= 1'b1;
    wr(`GTM_CTL, 32'h13);
    rdc(`GTM_AVAL, 32'hFFFFFFFF, 32'h1, "rtcstart");
    run <= 2'h1;
    waitIrq(300);
    rdc(`GTM_RIS, 32'h8, 32'h8, "rtcflag");
    repeat (4) begin
      repeat (10) @(posedge clk);
      apb(1'b0, `GTM_AVAL, 32'h0);
      chk("rollover", r <= 32'h2, 1'b1);
    end
    // Stop the slow clock so no new match races the clear
    run <= 2'h0;
    wr(`GTM_ICR, 32'h8);
    rdc(`GTM_RIS, 32'h8, 32'h0, "rtcclr");
    end_sim;
  end
endmodule // gtm_timer_test
